// ==== common/irq_pkg.sv ====
// Shared constants for the prioritised interrupt controller
package irq_pkg;
  // ************************************************************
  // Sources and priorities
  // ************************************************************
  localparam int NUM_PRIO = 24;
  localparam int PRIO_IDX_W = 5;
  // Priority 0 is reset; 1..10 and 23 are real sources
  localparam logic [23:0] SRC_IMPL = 24'h8007fe;
  localparam logic [23:0] POSTED_RST = 24'h000000;
  localparam logic [23:0] MASK_RST = 24'h000000;
  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_POSTED = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_SOFT_EN = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam int SOFT_EN_BIT = 0;
  localparam int GIE_BIT = 0;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ************************************************************
  // Sequencer timing
  // ************************************************************
  localparam logic [3:0] ENTRY_CYCLES = 4'hd;
  localparam logic [3:0] LONG_JUMP_INSTR_CYCLES = 4'h7;
  localparam logic [3:0] RET_CYCLES = 4'h4;
  localparam logic [3:0] STEP_PUSH_PCH = 4'h0;
  localparam logic [3:0] STEP_PUSH_PCL = 4'h1;
  localparam logic [3:0] STEP_PUSH_FLAGS = 4'h2;
  localparam logic [3:0] STEP_CLR_FLAGS = 4'h3;
  localparam logic [3:0] STEP_ZERO_PCH = 4'h4;
  localparam logic [3:0] STEP_VECTOR = 4'h5;
  localparam logic [3:0] RET_POP_FLAGS = 4'h1;
  localparam logic [3:0] RET_POP_PCL = 4'h2;
  localparam logic [3:0] RET_POP_PCH = 4'h3;
  typedef enum logic [1:0] {S_RUN, S_ENTRY, S_LONG_JUMP_INSTR, S_RETURN} seq_state_e;
endpackage : irq_pkg

// ==== src/irq_controller.sv ====
// Prioritised interrupt controller with CPU entry and return sequencer
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// ************************************************************
module irq_controller (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Interrupt sources, one-cycle events
  input wire logic [irq_pkg::NUM_PRIO-1:0] src_event_i,
  // CPU core
  input wire logic instr_done_i,
  input wire logic return_from_irq_instr_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] pop_data_i,
  output logic cpu_hold_o,
  output logic push_o,
  output logic [7:0] push_data_o,
  output logic pop_o,
  output logic pc_load_o,
  output logic [15:0] pc_o,
  output logic handler_start_o,
  output logic [7:0] flags_o,
  // AXI4-Lite write
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // AXI4-Lite read
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o
);
  import irq_pkg::*;

  localparam logic [3:0] ENTRY_LAST = ENTRY_CYCLES - 4'h1;
  localparam logic [3:0] LONG_JUMP_INSTR_LAST = LONG_JUMP_INSTR_CYCLES - 4'h1;
  localparam logic [3:0] RET_LAST = RET_CYCLES - 4'h1;

  logic rst_ff1_q, rst_n;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rd_val, wbe;
  logic [3:0] wstrb_q;
  logic [23:0] posted_q, posted_d, mask_q, pending, sw_set, sw_clr, take_clr;
  logic soft_en_q;
  logic [7:0] flags_q, vector, push_data_q;
  seq_state_e state_q;
  logic [3:0] cnt_q;
  logic [15:0] ret_pc_q, pc_q;
  logic hold_q, push_q, pop_q, pc_load_q, handler_q;
  logic enc_valid, take, wr_fire, wr_hit, rd_hit, wr_posted, wr_mask, wr_flags;
  logic [PRIO_IDX_W-1:0] enc_idx;
  logic in_entry, in_ret, vec_rd, start_entry, start_ret, ret_end, long_jump_instr_end;

  // ************************************************************
  // Reset release
  // ************************************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_ff1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_ff1_q <= 1'b1;
      rst_n <= rst_ff1_q;
    end
  end

  // ************************************************************
  // Bus slave
  // ************************************************************
  assign wr_fire = !awready_q && !wready_q && !bvalid_q;
  assign wr_hit = awaddr_q inside {OFS_POSTED, OFS_MASK, OFS_SOFT_EN, OFS_FLAGS, OFS_STATUS};
  assign rd_hit = s_axi_araddr_i inside {OFS_POSTED, OFS_MASK, OFS_SOFT_EN, OFS_FLAGS,
                                         OFS_STATUS};
  assign wr_posted = wr_fire && awaddr_q == OFS_POSTED;
  assign wr_mask = wr_fire && awaddr_q == OFS_MASK;
  assign wr_flags = wr_fire && awaddr_q == OFS_FLAGS && wstrb_q[0];

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wbe[8*b +: 8] = {8{wstrb_q[b]}};
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && awready_q) begin
        awaddr_q <= s_axi_awaddr_i;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid_i && wready_q) begin
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_val = 32'h0;
    unique case (s_axi_araddr_i)
      OFS_POSTED: rd_val = {8'h00, posted_q};
      OFS_MASK: rd_val = {8'h00, mask_q};
      OFS_SOFT_EN: rd_val[SOFT_EN_BIT] = soft_en_q;
      OFS_FLAGS: rd_val = {24'h0, flags_q};
      OFS_STATUS: rd_val = {23'h0, take, vector};
      default: rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid_i && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_q && s_axi_rready_i) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ************************************************************
  // Posted and pending sets
  // ************************************************************
  assign sw_set = {24{wr_posted && soft_en_q}} & wdata_q[23:0] & wbe[23:0];
  assign sw_clr = {24{wr_posted && !soft_en_q}} & ~wdata_q[23:0] & wbe[23:0];

  for (genvar g = 0; g < NUM_PRIO; g++) begin : g_src
    assign take_clr[g] = vec_rd && enc_valid && enc_idx == PRIO_IDX_W'(g);
    // Event and software post win over any clear in the same cycle
    assign posted_d[g] = SRC_IMPL[g] && (src_event_i[g] || sw_set[g] ||
                         (posted_q[g] && !sw_clr[g] && !take_clr[g]));
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      posted_q <= POSTED_RST;
    end else begin
      posted_q <= posted_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= MASK_RST;
      soft_en_q <= 1'b0;
    end else begin
      if (wr_mask) begin
        mask_q <= (mask_q & ~wbe[23:0]) | (wdata_q[23:0] & wbe[23:0] & SRC_IMPL);
      end
      if (wr_fire && awaddr_q == OFS_SOFT_EN && wstrb_q[0]) begin
        soft_en_q <= wdata_q[SOFT_EN_BIT];
      end
    end
  end

  assign pending = posted_q & mask_q;

  prio_encoder #(.N(NUM_PRIO), .IW(PRIO_IDX_W)) u_enc (
    .pend_i(pending),
    .valid_o(enc_valid),
    .idx_o(enc_idx)
  );

  assign vector = {1'b0, enc_idx, 2'b00};
  assign take = flags_q[GIE_BIT] && enc_valid;

  // ************************************************************
  // Entry and return sequencer
  // ************************************************************
  assign in_entry = state_q == S_ENTRY;
  assign in_ret = state_q == S_RETURN;
  assign vec_rd = in_entry && cnt_q == STEP_VECTOR;
  assign start_ret = state_q == S_RUN && return_from_irq_instr_i;
  assign start_entry = state_q == S_RUN && !return_from_irq_instr_i && take && instr_done_i;
  assign ret_end = in_ret && cnt_q == RET_LAST;
  assign long_jump_instr_end = state_q == S_LONG_JUMP_INSTR && cnt_q == LONG_JUMP_INSTR_LAST;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_RUN;
      cnt_q <= 4'h0;
      ret_pc_q <= 16'h0;
    end else begin
      unique case (state_q)
        S_RUN: begin
          if (start_ret) begin
            state_q <= S_RETURN;
            cnt_q <= 4'h0;
          end else if (start_entry) begin
            state_q <= S_ENTRY;
            cnt_q <= 4'h0;
            ret_pc_q <= pc_i;
          end
        end
        S_ENTRY: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == ENTRY_LAST) begin
            state_q <= S_LONG_JUMP_INSTR;
            cnt_q <= 4'h0;
          end
        end
        S_LONG_JUMP_INSTR: begin
          cnt_q <= cnt_q + 4'h1;
          if (long_jump_instr_end) begin
            state_q <= S_RUN;
            cnt_q <= 4'h0;
          end
        end
        S_RETURN: begin
          cnt_q <= cnt_q + 4'h1;
          if (ret_end) begin
            cnt_q <= 4'h0;
            // Serve what is still pending before the next instruction
            if (take) begin
              state_q <= S_ENTRY;
              ret_pc_q <= {pop_data_i, pc_q[7:0]};
            end else begin
              state_q <= S_RUN;
            end
          end
        end
      endcase
    end
  end

  // Flags: sequencer wins over software writes
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= FLAGS_RST;
    end else if (in_entry && cnt_q == STEP_CLR_FLAGS) begin
      flags_q <= 8'h00;
    end else if (in_ret && cnt_q == RET_POP_FLAGS) begin
      flags_q <= pop_data_i;
    end else if (wr_flags) begin
      flags_q <= wdata_q[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= 16'h0;
      pc_load_q <= 1'b0;
    end else begin
      pc_load_q <= vec_rd || ret_end;
      if (in_entry && cnt_q == STEP_ZERO_PCH) begin
        pc_q[15:8] <= 8'h00;
      end
      if (vec_rd) begin
        pc_q[7:0] <= vector;
      end
      if (in_ret && cnt_q == RET_POP_PCL) begin
        pc_q[7:0] <= pop_data_i;
      end
      if (in_ret && cnt_q == RET_POP_PCH) begin
        pc_q[15:8] <= pop_data_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      push_q <= 1'b0;
      push_data_q <= 8'h00;
      pop_q <= 1'b0;
    end else begin
      push_q <= in_entry && cnt_q <= STEP_PUSH_FLAGS;
      unique case (cnt_q)
        STEP_PUSH_PCH: push_data_q <= ret_pc_q[15:8];
        STEP_PUSH_PCL: push_data_q <= ret_pc_q[7:0];
        default: push_data_q <= flags_q;
      endcase
      pop_q <= in_ret && cnt_q < RET_LAST;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 1'b0;
      handler_q <= 1'b0;
    end else begin
      hold_q <= start_entry || start_ret ||
                (state_q != S_RUN && !long_jump_instr_end && !(ret_end && !take));
      handler_q <= long_jump_instr_end;
    end
  end

  assign cpu_hold_o = hold_q;
  assign push_o = push_q;
  assign push_data_o = push_data_q;
  assign pop_o = pop_q;
  assign pc_load_o = pc_load_q;
  assign pc_o = pc_q;
  assign handler_start_o = handler_q;
  assign flags_o = flags_q;
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  a_active_starts: assert property (start_entry |=> in_entry && cnt_q == 4'h0)
    else $error("active interrupt did not start entry");
  a_wait_instr: assert property (state_q == S_RUN && !instr_done_i |=> !in_entry)
    else $error("entry began before instruction end");
  a_entry_len: assert property (start_entry |-> ##13
    (in_entry && cnt_q == 4'hc) ##1 (state_q == S_LONG_JUMP_INSTR))
    else $error("entry length is not 13 cycles");
  a_push_order: assert property ($rose(push_o) |-> push_data_o == ret_pc_q[15:8]
    ##1 (push_o && push_data_o == ret_pc_q[7:0]) ##1 (push_o && push_data_o == flags_q)
    ##1 !push_o)
    else $error("stack push order wrong");
  a_flags_clear: assert property (in_entry && cnt_q == STEP_CLR_FLAGS |=>
    flags_o == 8'h00)
    else $error("flags not cleared on entry");
  a_vector_load: assert property (vec_rd && enc_valid |=>
    pc_load_o && pc_o == {8'h00, 1'b0, $past(enc_idx), 2'b00})
    else $error("vector not loaded into pc");
  a_take_clear: assert property (vec_rd && enc_valid && !src_event_i[enc_idx]
    && !sw_set[enc_idx] |=> !posted_q[$past(enc_idx)])
    else $error("taken posted bit not cleared");
  a_posted_hold: assert property (1'b1 |=>
    ($past(posted_q) & ~posted_q & ~($past(sw_clr) | $past(take_clr))) == 24'h0)
    else $error("posted bit lost without clear");
  a_gie_gate: assert property (state_q == S_RUN && !flags_q[GIE_BIT] |=> !in_entry)
    else $error("interrupt taken with enable off");
  a_prio_win: assert property (enc_valid |->
    (pending & ((24'h1 << enc_idx) - 24'h1)) == 24'h0 && pending[enc_idx])
    else $error("encoder did not pick highest priority");
  a_long_jump_instr_len: assert property (state_q == S_LONG_JUMP_INSTR && cnt_q == 4'h0 |->
    ##7 handler_start_o)
    else $error("handler start not after seven cycles");
  a_ret_flags: assert property (in_ret && cnt_q == RET_POP_FLAGS |=>
    flags_o == $past(pop_data_i))
    else $error("flags not restored on return");
  a_reservice: assert property (ret_end && take |=> in_entry)
    else $error("pending interrupt not served after return");
  a_soft_post: assert property (wr_posted && soft_en_q |=>
    (posted_q & $past(sw_set)) == $past(sw_set))
    else $error("software post lost");

  c_entry: cover property (start_entry ##21 handler_start_o);
  c_reservice: cover property (ret_end && take);
  c_soft_post: cover property (wr_posted && soft_en_q && sw_set != 24'h0);
  c_two_pending: cover property (enc_valid && $countones(pending) > 1 && vec_rd);
endmodule : irq_controller
`default_nettype wire

// ==== src/prio_encoder.sv ====
// Fixed-priority encoder, lowest index wins
`timescale 1ns/1ps
`default_nettype none
module prio_encoder #(
  parameter int N = 24,
  parameter int IW = 5
) (
  // Pending set
  input wire logic [N-1:0] pend_i,
  // Winner
  output logic valid_o,
  output logic [IW-1:0] idx_o
);
  always_comb begin
    valid_o = 1'b0;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend_i[i]) begin
        valid_o = 1'b1;
        idx_o = IW'(i);
      end
    end
  end
endmodule : prio_encoder
`default_nettype wire

// ==== verif/cpu_core_model.sv ====
// Behavioural CPU core facing the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model #(
  parameter logic [15:0] PC_HOME = 16'h1234
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Instruction length in cycles, 1 to 4
  input wire logic [2:0] ilen_i,
  // Controller side
  input wire logic hold_i,
  input wire logic push_i,
  input wire logic [7:0] push_data_i,
  input wire logic pop_i,
  input wire logic pc_load_i,
  input wire logic [15:0] pc_new_i,
  output logic instr_done_o,
  output logic [15:0] pc_o,
  output logic [7:0] pop_data_o
);
  // Sixteen bytes deep; the stimulus never nests handlers
  logic [7:0] stack_q [0:15];
  logic [3:0] sp_q;
  logic [2:0] cnt_q;
  logic [7:0] noise_q;
  // ************************************************************
  // Stack, read combinationally; toggles while unused
  // ************************************************************
  assign pop_data_o = pop_i ? stack_q[sp_q - 4'h1] : noise_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sp_q <= 4'h0;
      noise_q <= 8'h5a;
    end else begin
      noise_q <= ~noise_q;
      if (push_i) begin
        stack_q[sp_q] <= push_data_i;
        sp_q <= sp_q + 4'h1;
      end else if (pop_i) begin
        sp_q <= sp_q - 4'h1;
      end
    end
  end
  // Instruction boundaries only while the core runs
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 3'h1;
      instr_done_o <= 1'b0;
      pc_o <= PC_HOME;
    end else begin
      if (pc_load_i) begin
        pc_o <= pc_new_i;
      end
      instr_done_o <= !hold_i && cnt_q == 3'h1;
      cnt_q <= (hold_i || cnt_q == 3'h1) ? ilen_i : cnt_q - 3'h1;
    end
  end
endmodule : cpu_core_model
`default_nettype wire

// ==== verif/irq_controller_bench.sv ====
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module irq_controller_bench;
  import irq_pkg::*;
  typedef struct {logic [1:0] kind; logic [31:0] val;} note_s;
  localparam logic [15:0] PC_HOME = 16'h1234;
  logic clk_i = 1'b0;
  logic rstn_i, return_from_irq_instr, awvalid, wvalid, bready, arvalid, rready, instr_done;
  logic cpu_hold, push, pop, pc_load, hs, awready, wready, bvalid, arready, rvalid;
  logic [23:0] src, ev, m;
  logic [7:0] awaddr, araddr, pop_data, push_data, flags;
  logic [31:0] wdata, rdata;
  logic [15:0] pc, pc_new;
  logic [2:0] ilen;
  logic [1:0] bresp, rresp;
  int failures, tests_run, cyc, t0, pidx, seed, k, npop;
  note_s notes[$];
  always #50 clk_i = ~clk_i;
  irq_controller dut (.clk_i(clk_i), .rstn_i(rstn_i), .src_event_i(src),
    .instr_done_i(instr_done), .return_from_irq_instr_i(return_from_irq_instr), .pc_i(pc), .pop_data_i(pop_data),
    .cpu_hold_o(cpu_hold), .push_o(push), .push_data_o(push_data), .pop_o(pop),
    .pc_load_o(pc_load), .pc_o(pc_new), .handler_start_o(hs), .flags_o(flags),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp));
  cpu_core_model #(.PC_HOME(PC_HOME)) core (.clk_i(clk_i), .rstn_i(rstn_i), .ilen_i(ilen),
    .hold_i(cpu_hold), .push_i(push), .push_data_i(push_data), .pop_i(pop),
    .pc_load_i(pc_load), .pc_new_i(pc_new), .instr_done_o(instr_done), .pc_o(pc),
    .pop_data_o(pop_data));
  // ************************************************************
  // Notes and result watcher
  // ************************************************************
  task note(input logic [1:0] k, input logic [31:0] v);
    notes.push_back('{k, v});
  endtask : note
  task take(input logic [1:0] k, input logic [31:0] got);
    note_s n;
    `CHK("note present", 1'b1, notes.size() > 0)
    if (notes.size() > 0) begin
      n = notes.pop_front();
      `CHK("result kind", n.kind, k)
      `CHK("result value", n.val, got)
    end
  endtask : take
  always @(posedge clk_i) begin
    cyc++;
    if (bvalid && bready) take(2'h0, {30'h0, bresp});
    if (rvalid && rready) begin
      take(2'h1, rdata);
      take(2'h0, {30'h0, rresp});
    end
    if (push) begin
      if (pidx == 0) t0 = cyc;
      pidx = (pidx + 1) % 3;
      take(2'h2, {24'h0, push_data});
    end
    if (pc_load) take(2'h3, {16'h0, pc_new});
    if (hs) `CHK("latency", int'(ENTRY_CYCLES) + int'(LONG_JUMP_INSTR_CYCLES) - 1, cyc - t0)
    if (hs) `CHK("hold at start", 1'b0, cpu_hold)
    if (pop) npop++;
  end
  // ************************************************************
  // Drivers
  // ************************************************************
  task complete_run;
    $display("comparisons %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  task guard(input int i);
    `CHK("wait bound", 1'b1, i < 200)
    if (i >= 200) complete_run();
  endtask : guard
  task axi(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    if (!wr) note(2'h1, d);
    note(2'h0, {30'h0, r});
    @(posedge clk_i);
    if (wr) begin
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    end else begin
      {araddr, arvalid, rready} <= {a, 2'b11};
    end
    for (i = 0; i < 200; i++) begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if ((bvalid && bready) || (rvalid && rready)) break;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    guard(i);
  endtask : axi
  task pulse(input logic [23:0] e);
    @(posedge clk_i);
    src <= e;
    @(posedge clk_i);
    src <= 24'h0;
  endtask : pulse
  task wait_hs;
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_i);
      if (hs) break;
    end
    guard(i);
  endtask : wait_hs
  task ret(input logic restore);
    int i;
    if (restore) note(2'h3, {16'h0, PC_HOME});
    npop = 0;
    @(posedge clk_i);
    return_from_irq_instr <= 1'b1;
    @(posedge clk_i);
    return_from_irq_instr <= 1'b0;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_i);
      if (!cpu_hold) break;
    end
    guard(i);
    `CHK("pop count", 3, npop)
  endtask : ret
  task expect_entry(input logic [7:0] vec);
    note(2'h2, {24'h0, PC_HOME[15:8]});
    note(2'h2, {24'h0, PC_HOME[7:0]});
    note(2'h2, 32'h1 << GIE_BIT);
    note(2'h3, {24'h0, vec});
  endtask : expect_entry
  function automatic logic [7:0] vec_of(input logic [23:0] p);
    int j;
    vec_of = 8'h0;
    for (j = 23; j >= 0; j--) if (p[j] && SRC_IMPL[j]) vec_of = 8'(j * 4);
  endfunction : vec_of
  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    seed = 32'hdd77;
    {rstn_i, return_from_irq_instr, awvalid, wvalid, bready, arvalid, rready} <= 7'h0;
    {src, awaddr, araddr, wdata} <= 72'h0;
    ilen <= 3'(($random(seed) & 3) + 1);
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    axi(0, OFS_POSTED, {8'h0, POSTED_RST}, RESP_OKAY);
    axi(0, OFS_MASK, {8'h0, MASK_RST}, RESP_OKAY);
    axi(0, OFS_FLAGS, {24'h0, FLAGS_RST}, RESP_OKAY);
    axi(0, 8'h14, 32'h0, RESP_DECERR);
    axi(1, 8'h18, 32'hffffffff, RESP_DECERR);
    $display("test reset done");
    axi(1, OFS_POSTED, 32'hffffff, RESP_OKAY);
    axi(0, OFS_POSTED, 32'h0, RESP_OKAY);
    axi(1, OFS_SOFT_EN, 32'h1, RESP_OKAY);
    axi(0, OFS_SOFT_EN, 32'h1, RESP_OKAY);
    axi(1, OFS_POSTED, 32'h220, RESP_OKAY);
    axi(1, OFS_POSTED, 32'h0, RESP_OKAY);
    axi(0, OFS_POSTED, 32'h220, RESP_OKAY);
    axi(1, OFS_SOFT_EN, 32'h0, RESP_OKAY);
    axi(1, OFS_POSTED, 32'hffffdf, RESP_OKAY);
    axi(0, OFS_POSTED, 32'h200, RESP_OKAY);
    $display("test software post done");
    for (k = 0; k < 4; k++) begin
      ev = 24'($random(seed));
      m = 24'($random(seed));
      axi(1, OFS_POSTED, 32'h0, RESP_OKAY);
      axi(1, OFS_MASK, {8'h0, m}, RESP_OKAY);
      axi(0, OFS_MASK, {8'h0, m & SRC_IMPL}, RESP_OKAY);
      pulse(ev);
      axi(0, OFS_POSTED, {8'h0, ev & SRC_IMPL}, RESP_OKAY);
      axi(0, OFS_STATUS, {24'h0, vec_of(ev & m)}, RESP_OKAY);
      axi(1, OFS_MASK, 32'h0, RESP_OKAY);
      axi(0, OFS_POSTED, {8'h0, ev & SRC_IMPL}, RESP_OKAY);
    end
    $display("test priority done");
    axi(1, OFS_POSTED, 32'h0, RESP_OKAY);
    axi(1, OFS_FLAGS, 32'h1, RESP_OKAY);
    pulse(24'h000220);
    axi(1, OFS_MASK, 32'hffffff, RESP_OKAY);
    expect_entry(8'h14);
    wait_hs();
    `CHK("flags at handler", 8'h00, flags)
    axi(0, OFS_FLAGS, 32'h0, RESP_OKAY);
    axi(0, OFS_POSTED, 32'h200, RESP_OKAY);
    note(2'h3, {16'h0, PC_HOME});
    expect_entry(8'h24);
    ret(1'b0);
    ret(1'b1);
    axi(0, OFS_FLAGS, 32'h1, RESP_OKAY);
    expect_entry(8'h5c);
    pulse(24'h800000);
    wait_hs();
    ret(1'b1);
    axi(1, OFS_FLAGS, 32'h0, RESP_OKAY);
    pulse(24'h000002);
    axi(0, OFS_STATUS, 32'h4, RESP_OKAY);
    axi(1, OFS_FLAGS, 32'h1, RESP_OKAY);
    expect_entry(8'h04);
    wait_hs();
    ret(1'b1);
    $display("test entry and return done");
    complete_run();
  end
endmodule : irq_controller_bench
`default_nettype wire
